// ===== pkg/adc_port_pkg.sv
// constants, types and field layout of the converter serial command port
package adc_port_pkg;

  // modulator period in system clocks, 0 standing for 16
  localparam logic [3:0]  MOD_SYS_NORMAL = 4'h0;
  localparam logic [3:0]  MOD_SYS_TURBO  = 4'h8;
  // timeout in modulator periods
  localparam int unsigned TO_MODS_NORMAL = 13955;
  localparam int unsigned TO_MODS_TURBO  = 27910;
  localparam logic [15:0] READY_PULSE_MODS = 16'h0002;

  // result codes
  localparam logic [23:0]        CODE_MAX = 24'h7fffff;
  localparam logic [23:0]        CODE_MIN = 24'h800000;
  localparam logic signed [25:0] SUM_MAX  = 26'sh07fffff;
  localparam logic signed [25:0] SUM_MIN  = 26'sh3800000;

  // opcodes (upper seven bits) and upper nibbles
  localparam logic [6:0] OP_RESET = 7'h03;
  localparam logic [6:0] OP_START = 7'h04;
  localparam logic [6:0] OP_SLEEP = 7'h01;
  localparam logic [3:0] NIB_READ = 4'h1;
  localparam logic [3:0] NIB_CFG_READ_CMD = 4'h2;
  localparam logic [3:0] NIB_CFG_WRITE_CMD = 4'h4;

  // configuration field positions
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam int         CFG_MODE_REG  = 1;
  localparam int         MODE_LSB      = 3;
  localparam logic [1:0] MODE_TURBO    = 2'h2;
  localparam int         CONT_BIT      = 2;
  localparam int         CFG_READY_ON_OUT_PIN_SEL_REG = 3;
  localparam int         READY_ON_OUT_PIN_SEL_BIT     = 1;

  // bus offsets
  localparam logic [11:0] A_CFG    = 12'h000;
  localparam logic [11:0] A_RESULT = 12'h004;
  localparam logic [11:0] A_STATUS = 12'h008;
  localparam logic [11:0] A_CTRL   = 12'h00c;
  localparam logic [15:0] CONV_MODS_RESET = 16'h0040;
  localparam logic [15:0] CONV_MODS_MIN   = 16'h0003;

  typedef enum logic [1:0] {S_CMD, S_RDATA, S_CFG_READ_CMD, S_CFG_WRITE_CMD} spi_state_t;
  typedef enum logic [1:0] {C_IDLE, C_RUN, C_SLEEP} conv_state_t;

  typedef struct packed {
    logic turbo;
    logic continuous;
    logic ready_on_out_pin_sel;
  } mode_t;

  typedef struct packed {
    logic [1:0] spi_state;
    logic [1:0] conv_state;
    logic       run_cont;
    logic       sleep_pending;
    logic       ready_n;
  } status_t;

endpackage

// ===== src/adc_serial_command_port.sv
// serial command port of the converter with its ahb-lite control slave
`timescale 1ns/10ps
`default_nettype none

module adc_serial_command_port #(
  parameter int unsigned TIMEOUT_NORMAL_MODS = adc_port_pkg::TO_MODS_NORMAL,
  parameter int unsigned TIMEOUT_TURBO_MODS  = adc_port_pkg::TO_MODS_TURBO
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // serial pins
  input  wire logic              cs_n,
  input  wire logic              sclk,
  input  wire logic              din,
  output logic                   shared_out_ready_pin,
  output logic                   shared_out_ready_oe_n,
  output logic                   conversion_ready_n,
  // filter output
  input  wire logic signed [25:0] filter_sum
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edges
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic       sclk_prev;
  logic       cs_hi;
  logic       sclk_s;
  logic       din_s;
  logic       sclk_rise;
  logic       sclk_fall;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta  <= 3'h4;
      pin_sync  <= 3'h4;
      sclk_prev <= 1'b0;
    end else begin
      pin_meta  <= {cs_n, sclk, din};
      pin_sync  <= pin_meta;
      sclk_prev <= pin_sync[1];
    end
  end

  assign cs_hi     = pin_sync[2];
  assign sclk_s    = pin_sync[1];
  assign din_s     = pin_sync[0];
  assign sclk_rise = !cs_hi && sclk_s && !sclk_prev;
  assign sclk_fall = !cs_hi && !sclk_s && sclk_prev;

  ////////////////////////////////////////////////////////////////////////////
  // configuration and mode
  logic [7:0]              cfg [4];
  logic [7:0]              pend [4];
  logic [7:0]              merged [4];
  adc_port_pkg::mode_t     mode;
  logic [3:0]              mod_div;
  logic [3:0]              mod_last;
  logic                    mod_tick;

  assign mode.turbo      = cfg[adc_port_pkg::CFG_MODE_REG][adc_port_pkg::MODE_LSB +: 2]
                           == adc_port_pkg::MODE_TURBO;
  assign mode.continuous = cfg[adc_port_pkg::CFG_MODE_REG][adc_port_pkg::CONT_BIT];
  assign mode.ready_on_out_pin_sel      = cfg[adc_port_pkg::CFG_READY_ON_OUT_PIN_SEL_REG][adc_port_pkg::READY_ON_OUT_PIN_SEL_BIT];

  assign mod_last = (mode.turbo ? adc_port_pkg::MOD_SYS_TURBO
                                : adc_port_pkg::MOD_SYS_NORMAL) - 4'h1;
  assign mod_tick = mod_div == mod_last;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_div <= 4'h0;
    end else if (mod_tick) begin
      mod_div <= 4'h0;
    end else begin
      mod_div <= mod_div + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial sequencer
  adc_port_pkg::spi_state_t st;
  logic [2:0]  bits;
  logic [7:0]  rx;
  logic [7:0]  byte_val;
  logic        byte_done;
  logic [1:0]  reg_addr;
  logic [1:0]  bytes_left;
  logic [23:0] tx;
  logic [23:0] result;
  logic [14:0] to_cnt;
  logic [14:0] to_limit;
  logic        busy;
  logic        timeout_hit;
  logic        in_cmd;
  logic        cmd_reset;
  logic        cmd_start;
  logic        cmd_sleep;
  logic        cmd_read;
  logic        cmd_cfg_read_cmd;
  logic        cmd_cfg_write_cmd;
  logic        cfg_write_cmd_commit;
  logic        next_ready_n;

  assign busy        = (st != adc_port_pkg::S_CMD) || (bits != 3'h0);
  assign to_limit    = mode.turbo ? 15'(TIMEOUT_TURBO_MODS) : 15'(TIMEOUT_NORMAL_MODS);
  assign timeout_hit = busy && (to_cnt >= to_limit);
  assign byte_val    = {rx[6:0], din_s};
  assign byte_done   = sclk_fall && (bits == 3'h7) && !timeout_hit;
  assign in_cmd      = byte_done && (st == adc_port_pkg::S_CMD);
  assign cmd_reset   = in_cmd && byte_val[7:1] == adc_port_pkg::OP_RESET;
  assign cmd_start   = in_cmd && byte_val[7:1] == adc_port_pkg::OP_START;
  assign cmd_sleep   = in_cmd && byte_val[7:1] == adc_port_pkg::OP_SLEEP;
  assign cmd_read    = in_cmd && byte_val[7:4] == adc_port_pkg::NIB_READ;
  assign cmd_cfg_read_cmd    = in_cmd && byte_val[7:4] == adc_port_pkg::NIB_CFG_READ_CMD;
  assign cmd_cfg_write_cmd    = in_cmd && byte_val[7:4] == adc_port_pkg::NIB_CFG_WRITE_CMD;
  assign cfg_write_cmd_commit = byte_done && st == adc_port_pkg::S_CFG_WRITE_CMD
                       && bytes_left == 2'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st         <= adc_port_pkg::S_CMD;
      bits       <= 3'h0;
      rx         <= 8'h00;
      reg_addr   <= 2'h0;
      bytes_left <= 2'h0;
    end else if (cs_hi || timeout_hit) begin
      st   <= adc_port_pkg::S_CMD;
      bits <= 3'h0;
    end else if (sclk_fall) begin
      rx   <= byte_val;
      bits <= bits + 3'h1;
      if (byte_done) begin
        case (st)
          adc_port_pkg::S_CMD: begin
            reg_addr   <= byte_val[3:2];
            bytes_left <= byte_val[1:0];
            if (cmd_read) begin
              st         <= adc_port_pkg::S_RDATA;
              bytes_left <= 2'h2;
            end else if (cmd_cfg_read_cmd) begin
              st <= adc_port_pkg::S_CFG_READ_CMD;
            end else if (cmd_cfg_write_cmd) begin
              st <= adc_port_pkg::S_CFG_WRITE_CMD;
            end
          end
          adc_port_pkg::S_RDATA, adc_port_pkg::S_CFG_READ_CMD, adc_port_pkg::S_CFG_WRITE_CMD: begin
            reg_addr   <= reg_addr + 2'h1;
            bytes_left <= bytes_left - 2'h1;
            if (bytes_left == 2'h0) begin
              st <= adc_port_pkg::S_CMD;
            end
          end
          default: st <= adc_port_pkg::S_CMD;
        endcase
      end
    end
  end

  // timeout counter in modulator periods
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      to_cnt <= 15'h0000;
    end else if (!busy || cs_hi || sclk_rise || sclk_fall) begin
      to_cnt <= 15'h0000;
    end else if (mod_tick && !timeout_hit) begin
      to_cnt <= to_cnt + 15'h0001;
    end
  end

  // output shift register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx <= 24'h000000;
    end else if (cmd_read) begin
      tx <= result;
    end else if (cmd_cfg_read_cmd) begin
      tx <= {cfg[byte_val[3:2]], 16'h0000};
    end else if (byte_done && st == adc_port_pkg::S_CFG_READ_CMD) begin
      tx <= {cfg[reg_addr + 2'h1], 16'h0000};
    end else if (sclk_rise && (st == adc_port_pkg::S_RDATA || st == adc_port_pkg::S_CFG_READ_CMD)) begin
      tx <= {tx[22:0], 1'b0};
    end
  end

  // shared data/ready pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shared_out_ready_pin  <= 1'b1;
      shared_out_ready_oe_n <= 1'b1;
    end else begin
      shared_out_ready_oe_n <= cs_hi;
      if (st == adc_port_pkg::S_CMD) begin
        shared_out_ready_pin <= mode.ready_on_out_pin_sel ? next_ready_n : 1'b1;
      end else if (sclk_rise) begin
        shared_out_ready_pin <= tx[23];
      end
    end
  end

  // register staging and commit
  always_comb begin
    merged = pend;
    merged[reg_addr] = byte_val;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg  <= '{default: adc_port_pkg::CFG_RESET};
      pend <= '{default: adc_port_pkg::CFG_RESET};
    end else if (cmd_reset) begin
      cfg <= '{default: adc_port_pkg::CFG_RESET};
    end else if (cmd_cfg_write_cmd) begin
      pend <= cfg;
    end else if (cfg_write_cmd_commit) begin
      cfg <= merged;
    end else if (byte_done && st == adc_port_pkg::S_CFG_WRITE_CMD) begin
      pend <= merged;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  adc_port_pkg::conv_state_t cst;
  logic [15:0] conv_mods;
  logic [15:0] conv_cnt;
  logic        boot;
  logic        run_cont;
  logic        sleep_pending;
  logic        conv_done;
  logic        pre_pulse;
  logic        any_start;

  assign any_start = boot || cmd_start || cmd_reset || cfg_write_cmd_commit;
  assign conv_done = cst == adc_port_pkg::C_RUN && mod_tick
                     && conv_cnt == conv_mods - 16'h0001;
  assign pre_pulse = cst == adc_port_pkg::C_RUN && run_cont && mod_tick
                     && conv_cnt == conv_mods - adc_port_pkg::READY_PULSE_MODS - 16'h0001;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cst           <= adc_port_pkg::C_IDLE;
      conv_cnt      <= 16'h0000;
      boot          <= 1'b1;
      run_cont      <= 1'b0;
      sleep_pending <= 1'b0;
    end else begin
      boot <= 1'b0;
      if (any_start) begin
        cst           <= adc_port_pkg::C_RUN;
        conv_cnt      <= 16'h0000;
        run_cont      <= cmd_start && mode.continuous;
        sleep_pending <= 1'b0;
      end else if (cmd_sleep && cst != adc_port_pkg::C_RUN) begin
        cst <= adc_port_pkg::C_SLEEP;
      end else begin
        if (cmd_sleep) begin
          sleep_pending <= 1'b1;
        end
        case (cst)
          adc_port_pkg::C_RUN: begin
            if (conv_done) begin
              conv_cnt <= 16'h0000;
              if (sleep_pending || cmd_sleep) begin
                cst <= adc_port_pkg::C_SLEEP;
              end else if (!run_cont) begin
                cst <= adc_port_pkg::C_IDLE;
              end
            end else if (mod_tick) begin
              conv_cnt <= conv_cnt + 16'h0001;
            end
          end
          adc_port_pkg::C_IDLE, adc_port_pkg::C_SLEEP: conv_cnt <= 16'h0000;
          default: cst <= adc_port_pkg::C_IDLE;
        endcase
      end
    end
  end

  function automatic logic [23:0] saturate(input logic signed [25:0] v);
    if (v > adc_port_pkg::SUM_MAX) begin
      saturate = adc_port_pkg::CODE_MAX;
    end else if (v < adc_port_pkg::SUM_MIN) begin
      saturate = adc_port_pkg::CODE_MIN;
    end else begin
      saturate = v[23:0];
    end
  endfunction

  always_comb begin
    next_ready_n = conversion_ready_n;
    if (conv_done) begin
      next_ready_n = 1'b0;
    end else if (sclk_rise || pre_pulse) begin
      next_ready_n = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result             <= 24'h000000;
      conversion_ready_n <= 1'b1;
    end else begin
      conversion_ready_n <= next_ready_n;
      if (conv_done) begin
        result <= saturate(filter_sum);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave
  logic        ap_valid;
  logic        dp_write;
  logic [11:0] dp_addr;
  adc_port_pkg::status_t status;

  assign ap_valid  = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign status    = '{spi_state: st, conv_state: cst, run_cont: run_cont,
                       sleep_pending: sleep_pending, ready_n: conversion_ready_n};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr  <= 12'h000;
    end else begin
      dp_write <= ap_valid && hwrite;
      dp_addr  <= {haddr[11:2], 2'h0};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_mods <= adc_port_pkg::CONV_MODS_RESET;
    end else if (dp_write && dp_addr == adc_port_pkg::A_CTRL) begin
      conv_mods <= (hwdata[15:0] < adc_port_pkg::CONV_MODS_MIN)
                   ? adc_port_pkg::CONV_MODS_MIN : hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (ap_valid && !hwrite) begin
      case ({haddr[11:2], 2'h0})
        adc_port_pkg::A_CFG:    hrdata <= {cfg[3], cfg[2], cfg[1], cfg[0]};
        adc_port_pkg::A_RESULT: hrdata <= {8'h00, result};
        adc_port_pkg::A_STATUS: hrdata <= {25'h0000000, status};
        adc_port_pkg::A_CTRL:   hrdata <= {16'h0000, conv_mods};
        default:                hrdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_hiz_on_deselect: assert property (cs_hi |=> shared_out_ready_oe_n)
    else $error("shared pin driven while deselected");
  a_deselect_resets: assert property (cs_hi |=> st == adc_port_pkg::S_CMD && bits == 3'h0)
    else $error("interface not reset on deselect");
  a_ready_falls_done: assert property (conv_done |=> !conversion_ready_n ##1
                                       (conversion_ready_n == $past(sclk_rise || pre_pulse)))
    else $error("ready not low after conversion");
  a_ready_rises_sclk: assert property (sclk_rise && !conv_done |=> conversion_ready_n)
    else $error("ready not released on rising clock");
  a_timeout_resets: assert property (timeout_hit && !cs_hi |=> !busy)
    else $error("timeout did not reset interface");
  a_saturate_high: assert property (conv_done && filter_sum > adc_port_pkg::SUM_MAX
                                    |=> result == adc_port_pkg::CODE_MAX)
    else $error("positive saturation wrong");
  a_saturate_low: assert property (conv_done && filter_sum < adc_port_pkg::SUM_MIN
                                   |=> result == adc_port_pkg::CODE_MIN)
    else $error("negative saturation wrong");
  a_reset_defaults: assert property (cmd_reset |=> cfg[0] == 8'h00 && cfg[1] == 8'h00
                                     && cfg[2] == 8'h00 && cfg[3] == 8'h00)
    else $error("reset command left settings");
  a_read_loads: assert property (cmd_read |=> tx == $past(result)
                                 && st == adc_port_pkg::S_RDATA)
    else $error("read command did not load result");
  a_write_commit: assert property (cfg_write_cmd_commit |=> cfg[$past(reg_addr)] == $past(byte_val)
                                   && cst == adc_port_pkg::C_RUN)
    else $error("register write not committed");
  a_start_restarts: assert property (cmd_start |=> cst == adc_port_pkg::C_RUN
                                     && conv_cnt == 16'h0000)
    else $error("start did not restart conversion");

  c_read_data: cover property (cmd_read ##[1:1000] st == adc_port_pkg::S_CMD);
  c_reg_write: cover property (cfg_write_cmd_commit);
  c_timeout:   cover property (timeout_hit);
  c_pre_pulse: cover property (pre_pulse ##[1:200] conv_done);

endmodule

`default_nettype wire

// ===== test/host_spi_model.sv
// host side spi master model, mode 1
`timescale 1ns/10ps
`default_nettype none
module host_spi_model (
  // clock
  input  wire logic hclk,
  // serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // frame select; idle data line shows no stale value
  task automatic sel(input logic v);
    cs_n <= v;
    if (v) begin
      din <= ~din;
    end
    repeat (4) @(posedge hclk);
  endtask
  // drive on rise, sample late in low phase, clock idles low
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sclk <= 1'b1;
      din  <= tx[i];
      repeat (4) @(posedge hclk);
      sclk <= 1'b0;
      repeat (3) @(posedge hclk);
      rx[i] = dout;
      @(posedge hclk);
    end
  endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench of the converter serial command port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic               hclk;
  logic               hresetn;
  logic               hsel;
  logic [31:0]        haddr;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [2:0]         hsize;
  logic [31:0]        hwdata;
  logic [31:0]        hrdata;
  logic               hreadyout;
  logic               hresp;
  wire                cs_n;
  wire                sclk;
  wire                din;
  logic               pin;
  logic               oe_n;
  logic               rdy_n;
  logic signed [25:0] filter_sum;
  logic [31:0]        rd;
  int                 n_mismatch;
  int                 compares;
  wire                line = oe_n ? 1'bz : pin;

  adc_serial_command_port #(.TIMEOUT_NORMAL_MODS(20), .TIMEOUT_TURBO_MODS(40)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cs_n(cs_n), .sclk(sclk), .din(din),
    .shared_out_ready_pin(pin), .shared_out_ready_oe_n(oe_n),
    .conversion_ready_n(rdy_n), .filter_sum(filter_sum));
  host_spi_model u_host (.hclk(hclk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(line));

  ////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h0, a};
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic frame(input logic [7:0] op, input int n, input logic [7:0] tx);
    logic [7:0] b;
    u_host.sel(1'b0);
    u_host.bits(op, 8, b);
    rd = 32'h0;
    for (int i = 0; i < n; i++) begin
      u_host.bits(tx, 8, b);
      rd = {rd[23:0], b};
    end
    u_host.sel(1'b1);
  endtask
  // host watches the dedicated ready output
  task automatic wait_rdy;
    int k = 0;
    while (rdy_n !== 1'b0 && k < 3000) begin
      @(posedge hclk);
      k++;
    end
    chk("ready_fall", 32'h0, {31'h0, rdy_n});
  endtask
  // continuous start with unread results; ready high for two modulator periods
  task automatic ready_pulse(input logic [7:0] mode_byte, input int exp_cycles);
    int k;
    frame(8'h44, 1, mode_byte);
    wait_rdy;
    frame(8'h08, 0, 8'h00);
    wait_rdy;
    k = 0;
    while (rdy_n !== 1'b1 && k < 200) begin
      @(posedge hclk);
      k++;
    end
    k = 0;
    while (rdy_n !== 1'b0 && k < 200) begin
      @(posedge hclk);
      k++;
    end
    chk("ready_pulse", exp_cycles, k);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    #3000000;
    n_mismatch++;
    close_out;
  end
  initial begin
    logic [7:0] b;
    hresetn    = 1'b0;
    hsize      = 3'h0;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hwdata     = 32'h0;
    filter_sum = 26'sh0123456;
    n_mismatch = 0;
    compares   = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    chk("oe_n_reset", 32'h1, {31'h0, oe_n});
    chk("ready_reset", 32'h1, {31'h0, rdy_n});
    ahb(1'b0, adc_port_pkg::A_CTRL, 32'h0);
    chk("ctrl_reset", 32'h40, rd);
    ahb(1'b1, adc_port_pkg::A_CTRL, 32'h1);
    ahb(1'b0, adc_port_pkg::A_CTRL, 32'h0);
    chk("ctrl_min", 32'h3, rd);
    ahb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h0, rd);
    // boot conversion, read by command
    wait_rdy;
    frame(8'h1f, 3, 8'h00);
    chk("rdata", 32'h123456, rd);
    chk("ready_rise", 32'h1, {31'h0, rdy_n});
    // saturation, both start codes
    for (int i = 0; i < 2; i++) begin
      filter_sum <= i ? 26'sh2000000 : 26'sh1000000;
      frame(8'h08 | 8'(i), 0, 8'h00);
      wait_rdy;
      ahb(1'b0, adc_port_pkg::A_RESULT, 32'h0);
      chk("sat", i ? 32'h800000 : 32'h7fffff, rd);
    end
    // write cfg3 and wrapped cfg0, read back
    frame(8'h4d, 2, 8'h02);
    ahb(1'b0, adc_port_pkg::A_CFG, 32'h0);
    chk("cfg_wr", 32'h02000002, rd);
    frame(8'h2e, 3, 8'h00);
    chk("cfg_rd", 32'h020200, rd);
    // ready on shared pin, release on deselect
    frame(8'h08, 0, 8'h00);
    wait_rdy;
    u_host.sel(1'b0);
    chk("pin_ready", 32'h0, {30'h0, oe_n, pin});
    u_host.sel(1'b1);
    chk("pin_float", 32'h1, {31'h0, oe_n});
    chk("ready_kept", 32'h0, {31'h0, rdy_n});
    // stalled half byte, then fresh aligned command
    u_host.sel(1'b0);
    u_host.bits(8'h00, 4, b);
    repeat (400) @(posedge hclk);
    u_host.bits(8'h20, 8, b);
    u_host.bits(8'h00, 8, b);
    u_host.sel(1'b1);
    chk("timeout", 32'h2, {24'h0, b});
    // sleep, then wake by start
    frame(8'h03, 0, 8'h00);
    repeat (100) @(posedge hclk);
    ahb(1'b0, adc_port_pkg::A_STATUS, 32'h0);
    chk("sleep", 32'h2, {30'h0, rd[4:3]});
    frame(8'h09, 0, 8'h00);
    wait_rdy;
    // reset command clears configuration
    frame(8'h06, 0, 8'h00);
    repeat (1040) @(posedge hclk);
    ahb(1'b0, adc_port_pkg::A_CFG, 32'h0);
    chk("cfg_rst", 32'h0, rd);
    // continuous, unread: ready pulse in normal, then turbo modulator periods
    ready_pulse(8'h04, 32);
    ready_pulse(8'h14, 16);
    close_out;
  end
endmodule
`default_nettype wire
